/* rfpa_map.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * radio front-end configuration register bank.
 * assumes inclusion by bare name from package and modules.
 */
`ifndef RFPA_MAP_SVH
`define RFPA_MAP_SVH

// ********************************************************************
// register indices; the byte address is the index times four
// ********************************************************************
`define RFPA_IDX_RX_TRIM      16'hdf1a
`define RFPA_IDX_TX_CFG       16'hdf1b
`define RFPA_IDX_CAL_A        16'hdf1c
`define RFPA_IDX_RAMP_CTRL    16'hdf20
`define RFPA_IDX_RAMP_STAT    16'hdf21
`define RFPA_IDX_CAL_RES      16'hdf22
`define RFPA_ADDR_W           18

// ********************************************************************
// field layout and reset values
// ********************************************************************
`define RFPA_RX_TRIM_RST      8'h56
`define RFPA_TX_LO_RST        2'h1
`define RFPA_PWR_IDX_RST      3'h0
`define RFPA_CAL_CFG_RST      2'h2
`define RFPA_PUMP_EN_RST      2'h2
`define RFPA_PUMP_RES_RST     4'h9
`define RFPA_RAMP_CTRL_RST    8'h00
`define RFPA_BYTE_F           7:0
`define RFPA_TX_LO_F          5:4
`define RFPA_PWR_IDX_F        2:0
`define RFPA_CAL_CFG_F        7:6
`define RFPA_PUMP_EN_F        5:4
`define RFPA_PUMP_RES_F       3:0
`define RFPA_ASK_MODE_B       0

// ********************************************************************
// timing: one ramp step lasts this long
// ********************************************************************
`define RFPA_STEP_NS          1000
`define RFPA_CLK_NS           100
`define RFPA_STEP_CYC         (`RFPA_STEP_NS / `RFPA_CLK_NS)

`endif

/* rfpa_pkg.sv */
/*
 * types of the radio front-end configuration register bank.
 * assumes rfpa_map.svh in the same folder.
 */
`include "rfpa_map.svh"

package rfpa_pkg;

    // ramp sequencer states
    typedef enum logic [1:0] {
        RFPA_IDLE = 2'b00,
        RFPA_UP   = 2'b01,
        RFPA_HOLD = 2'b10,
        RFPA_DOWN = 2'b11
    } rfpa_ramp_e;

    typedef logic [2:0] rfpa_idx_t;

endpackage : rfpa_pkg

/* rfpa_ramp.sv */
/*
 * power ramp and ask shaping sequencer: picks the power table entry in use.
 * assumes all inputs synchronous to clk.
 */
`timescale 1ns/1ps
`include "rfpa_map.svh"

module rfpa_ramp
    import rfpa_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // settings and transmit control
    input  wire rfpa_pkg::rfpa_idx_t tx_power_table_index,
    input  wire logic               tx_active,
    input  wire logic               ask_mode,
    input  wire logic               ask_symbol,
    // entry in use and state
    output logic [2:0]              entry_q,
    output rfpa_pkg::rfpa_ramp_e    state_q
);

    // ********************************************************************
    // next-state logic
    // ********************************************************************
    localparam logic [7:0] STEP_LAST = 8'(`RFPA_STEP_CYC - 1);

    rfpa_ramp_e state_d;
    logic [2:0] entry_d;
    logic [2:0] target;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       step;

    // ask zero symbol targets entry zero, else the programmed index
    always_comb begin
        target  = (ask_mode && !ask_symbol) ? 3'h0 : tx_power_table_index;
        step    = (cnt_q == STEP_LAST);
        cnt_d   = step ? 8'h00 : cnt_q + 8'h01;
        state_d = state_q;
        entry_d = entry_q;
        unique case (state_q)
            RFPA_IDLE: begin
                entry_d = 3'h0;
                cnt_d   = 8'h00;
                if (tx_active) begin
                    state_d = RFPA_UP;
                end
            end
            RFPA_UP, RFPA_HOLD: begin
                if (!tx_active) begin
                    state_d = RFPA_DOWN;
                end else if (step && entry_q < target) begin
                    entry_d = entry_q + 3'h1;
                    state_d = RFPA_UP;
                end else if (entry_q > target) begin
                    // above the target the ramp only falls, so it is no longer climbing
                    state_d = RFPA_HOLD;
                    if (step) begin
                        entry_d = entry_q - 3'h1;
                    end
                end else if (entry_q == target) begin
                    state_d = RFPA_HOLD;
                end
            end
            RFPA_DOWN: begin
                if (tx_active && entry_q > target) begin
                    state_d = RFPA_HOLD;
                end else if (tx_active) begin
                    state_d = RFPA_UP;
                end else if (step) begin
                    if (entry_q == 3'h0) begin
                        state_d = RFPA_IDLE;
                    end else begin
                        entry_d = entry_q - 3'h1;
                    end
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= RFPA_IDLE;
            entry_q <= 3'h0;
            cnt_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            entry_q <= entry_d;
            cnt_q   <= cnt_d;
        end
    end

    // entry never passes a steady programmed index while ramping up
    a_ramp_bound: assert property (@(posedge clk) disable iff (rst)
        (state_q == RFPA_UP && !ask_mode && $stable(tx_power_table_index)) |->
        entry_q <= tx_power_table_index)
        else $error("ramp entry above power index");

    // entry moves at most one step per edge
    a_ramp_single: assert property (@(posedge clk) disable iff (rst)
        (entry_q != $past(entry_q)) |->
        (entry_q == $past(entry_q) + 3'h1 || entry_q == $past(entry_q) - 3'h1))
        else $error("ramp jumped more than one entry");

    // idle state always shows entry zero
    a_idle_zero: assert property (@(posedge clk) disable iff (rst)
        (state_q == RFPA_IDLE) |-> entry_q == 3'h0)
        else $error("idle with nonzero entry");

endmodule : rfpa_ramp

/* rfpa_regs.sv */
/*
 * configuration register bank of a sub-ghz radio front end on ahb-lite:
 * receive current trims, transmit lo buffer trim, power table index and
 * synthesizer calibration bits, plus a ramp sequencer instance.
 * assumes a single ahb-lite master, word transfers only; radio core inputs
 * arrive from other clock domains and are synchronised here.
 */
// Register access over AHB-Lite was left to the implementer.
// Notes on behaviour
// - three-bit power index, reset zero, picks one of eight table entries.
// - ask: one symbol uses indexed entry, zero symbol uses entry zero.
// - ramp entries zero up to index at start, back down at end.
// - pump calibration stage skipped whenever two-bit enable field is zero; resets 10.
// - pump current result written by calibration, software writable, resets 1001.
// - four two-bit receive current trims, reset 01, 01, 01, 10.
// - transmit lo trim at bits five to four, reset 01, unused read zero.
`timescale 1ns/1ps
`include "rfpa_map.svh"

module rfpa_regs
    import rfpa_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // radio core inputs (asynchronous)
    input  wire logic        tx_active,
    input  wire logic        ask_symbol,
    input  wire logic        cal_done,
    input  wire logic [3:0]  pump_cal_result,
    // radio core settings
    output logic [7:0]       rx_frontend_current_trim,
    output logic [1:0]       tx_lo_buffer_current_trim,
    output logic [2:0]       tx_power_table_index,
    output logic [1:0]       synth_cal_config,
    output logic             pump_cal_stage_run,
    output logic [3:0]       pump_current,
    output logic [2:0]       power_table_entry
);

    // ********************************************************************
    // input synchronisers
    // ********************************************************************
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [6:0] sync_d;

    // first stage read only by the second stage
    always_comb begin
        sync_d = {tx_active, ask_symbol, cal_done, pump_cal_result};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end else begin
            sync1_q <= sync_d;
            sync2_q <= sync1_q;
        end
    end

    logic       cal_done_q;
    logic       cal_rise;
    logic [3:0] res_s;
    assign res_s    = sync2_q[3:0];
    assign cal_rise = sync2_q[4] && !cal_done_q;

    // ********************************************************************
    // ahb-lite address and data phase
    // ********************************************************************
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic        rd_pend_q;
    logic        rd_pend_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    logic        take;

    // a transfer is taken on a valid nonseq/seq address phase
    always_comb begin
        take      = hsel && hready && htrans[1];
        wr_pend_d = take && hwrite;
        rd_pend_d = take && !hwrite;
        addr_d    = take ? haddr[`RFPA_ADDR_W-1:2] : addr_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 16'h0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q    <= addr_d;
        end
    end

    // ********************************************************************
    // register file
    // ********************************************************************
    logic [7:0] rx_trim_q;
    logic [7:0] rx_trim_d;
    logic [1:0] tx_lo_q;
    logic [1:0] tx_lo_d;
    logic [2:0] pwr_idx_q;
    logic [2:0] pwr_idx_d;
    logic [1:0] cal_cfg_q;
    logic [1:0] cal_cfg_d;
    logic [1:0] pump_en_q;
    logic [1:0] pump_en_d;
    logic [3:0] pump_res_q;
    logic [3:0] pump_res_d;
    logic [7:0] ramp_ctrl_q;
    logic [7:0] ramp_ctrl_d;
    logic [7:0] wd;

    always_comb begin
        wd          = hwdata[`RFPA_BYTE_F];
        rx_trim_d   = rx_trim_q;
        tx_lo_d     = tx_lo_q;
        pwr_idx_d   = pwr_idx_q;
        cal_cfg_d   = cal_cfg_q;
        pump_en_d   = pump_en_q;
        pump_res_d  = pump_res_q;
        ramp_ctrl_d = ramp_ctrl_q;
        if (wr_pend_q) begin
            unique case (addr_q)
                `RFPA_IDX_RX_TRIM: begin
                    rx_trim_d = wd;
                end
                `RFPA_IDX_TX_CFG: begin
                    tx_lo_d   = wd[`RFPA_TX_LO_F];
                    pwr_idx_d = wd[`RFPA_PWR_IDX_F];
                end
                `RFPA_IDX_CAL_A: begin
                    cal_cfg_d  = wd[`RFPA_CAL_CFG_F];
                    pump_en_d  = wd[`RFPA_PUMP_EN_F];
                    pump_res_d = wd[`RFPA_PUMP_RES_F];
                end
                `RFPA_IDX_RAMP_CTRL: begin
                    ramp_ctrl_d = {7'h00, wd[`RFPA_ASK_MODE_B]};
                end
                default: begin
                end
            endcase
        end
        // calibration result wins over a write in the same cycle
        if (cal_rise && pump_en_q != 2'h0) begin
            pump_res_d = res_s;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_trim_q   <= `RFPA_RX_TRIM_RST;
            tx_lo_q     <= `RFPA_TX_LO_RST;
            pwr_idx_q   <= `RFPA_PWR_IDX_RST;
            cal_cfg_q   <= `RFPA_CAL_CFG_RST;
            pump_en_q   <= `RFPA_PUMP_EN_RST;
            pump_res_q  <= `RFPA_PUMP_RES_RST;
            ramp_ctrl_q <= `RFPA_RAMP_CTRL_RST;
            cal_done_q  <= 1'b0;
        end else begin
            rx_trim_q   <= rx_trim_d;
            tx_lo_q     <= tx_lo_d;
            pwr_idx_q   <= pwr_idx_d;
            cal_cfg_q   <= cal_cfg_d;
            pump_en_q   <= pump_en_d;
            pump_res_q  <= pump_res_d;
            ramp_ctrl_q <= ramp_ctrl_d;
            cal_done_q  <= sync2_q[4];
        end
    end

    // ********************************************************************
    // ramp sequencer
    // ********************************************************************
    logic [2:0] entry;
    rfpa_ramp_e ramp_state;

    rfpa_ramp u_ramp (
        .clk                  (clk),
        .rst                  (rst),
        .tx_power_table_index (pwr_idx_q),
        .tx_active            (sync2_q[6]),
        .ask_mode             (ramp_ctrl_q[`RFPA_ASK_MODE_B]),
        .ask_symbol           (sync2_q[5]),
        .entry_q              (entry),
        .state_q              (ramp_state)
    );

    // ********************************************************************
    // read data and registered outputs
    // ********************************************************************
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_pend_d) begin
            unique case (haddr[`RFPA_ADDR_W-1:2])
                `RFPA_IDX_RX_TRIM:   rdata_d[7:0] = rx_trim_q;
                `RFPA_IDX_TX_CFG: begin
                    // unused bits keep the zero given above
                    rdata_d[`RFPA_TX_LO_F]   = tx_lo_q;
                    rdata_d[`RFPA_PWR_IDX_F] = pwr_idx_q;
                end
                `RFPA_IDX_CAL_A: begin
                    rdata_d[`RFPA_CAL_CFG_F]  = cal_cfg_q;
                    rdata_d[`RFPA_PUMP_EN_F]  = pump_en_q;
                    rdata_d[`RFPA_PUMP_RES_F] = pump_res_q;
                end
                `RFPA_IDX_RAMP_CTRL: rdata_d[7:0] = ramp_ctrl_q;
                `RFPA_IDX_RAMP_STAT: rdata_d[7:0] = {3'h0, ramp_state, entry};
                default:             rdata_d      = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata                    <= 32'h0000_0000;
            hreadyout                 <= 1'b1;
            hresp                     <= 1'b0;
            rx_frontend_current_trim  <= `RFPA_RX_TRIM_RST;
            tx_lo_buffer_current_trim <= `RFPA_TX_LO_RST;
            tx_power_table_index      <= `RFPA_PWR_IDX_RST;
            synth_cal_config          <= `RFPA_CAL_CFG_RST;
            pump_cal_stage_run        <= 1'b1;
            pump_current              <= `RFPA_PUMP_RES_RST;
            power_table_entry         <= 3'h0;
        end else begin
            hrdata                    <= rdata_d;
            hreadyout                 <= 1'b1;
            hresp                     <= 1'b0;
            rx_frontend_current_trim  <= rx_trim_d;
            tx_lo_buffer_current_trim <= tx_lo_d;
            tx_power_table_index      <= pwr_idx_d;
            synth_cal_config          <= cal_cfg_d;
            pump_cal_stage_run        <= (pump_en_d != 2'h0);
            pump_current              <= pump_res_d;
            power_table_entry         <= entry;
        end
    end

    // enable zero means the stage never runs
    a_pump_skip: assert property (@(posedge clk) disable iff (rst)
        (pump_en_q == 2'h0) |-> !pump_cal_stage_run)
        else $error("pump calibration runs while disabled");

    // a written power index shows on the output from the edge the write lands
    a_index_write: assert property (@(posedge clk) disable iff (rst)
        (wr_pend_q && addr_q == `RFPA_IDX_TX_CFG) |=>
        tx_power_table_index == $past(hwdata[2:0]))
        else $error("power index not updated");

    // calibration edge loads result when enabled
    a_pump_result: assert property (@(posedge clk) disable iff (rst)
        (cal_rise && pump_en_q != 2'h0) |=> pump_res_q == $past(res_s))
        else $error("pump result not captured");

    // tx config unused bits read zero
    a_tx_unused: assert property (@(posedge clk) disable iff (rst)
        $past(rd_pend_d && haddr[`RFPA_ADDR_W-1:2] == `RFPA_IDX_TX_CFG) |->
        (hrdata[7:6] == 2'h0 && hrdata[3] == 1'b0))
        else $error("tx config unused bits nonzero");

    // calibration configuration kept unless written
    a_cal_cfg_hold: assert property (@(posedge clk) disable iff (rst)
        !(wr_pend_q && addr_q == `RFPA_IDX_CAL_A) |=> $stable(cal_cfg_q))
        else $error("calibration configuration changed without write");

endmodule : rfpa_regs

/* tb_top.sv */
/*
 * self-checking testbench of the radio front-end configuration register bank.
 * assumes rfpa_map.svh and rfpa_pkg in the same folder; the bench is the only
 * ahb-lite master and drives the radio core inputs itself.
 */
`timescale 1ns/1ps
`include "rfpa_map.svh"

module tb_top;
    import rfpa_pkg::*;

    // ********************************************************************
    // signals, clock and design instance
    // ********************************************************************
    logic        clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tx_active;
    logic        ask_symbol;
    logic        cal_done;
    logic [3:0]  pump_cal_result;
    logic [7:0]  rx_trim;
    logic [1:0]  tx_lo;
    logic [2:0]  pwr_idx;
    logic [1:0]  cal_cfg;
    logic        cal_run;
    logic [3:0]  pump_current;
    logic [2:0]  entry;
    int          err_total;
    int          n_checks;

    // free-running 10 mhz clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    rfpa_regs i_dut (
        .clk                       (clk),
        .rst                       (rst),
        .hsel                      (hsel),
        .haddr                     (haddr),
        .htrans                    (htrans),
        .hwrite                    (hwrite),
        .hsize                     (hsize),
        .hwdata                    (hwdata),
        .hready                    (hreadyout),
        .hrdata                    (hrdata),
        .hreadyout                 (hreadyout),
        .hresp                     (hresp),
        .tx_active                 (tx_active),
        .ask_symbol                (ask_symbol),
        .cal_done                  (cal_done),
        .pump_cal_result           (pump_cal_result),
        .rx_frontend_current_trim  (rx_trim),
        .tx_lo_buffer_current_trim (tx_lo),
        .tx_power_table_index      (pwr_idx),
        .synth_cal_config          (cal_cfg),
        .pump_cal_stage_run        (cal_run),
        .pump_current              (pump_current),
        .power_table_entry         (entry)
    );

    // ********************************************************************
    // checking, verdict and bus tasks
    // ********************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // a bounded wait ran out: count it and stop
    task automatic stall(input string msg);
        err_total++;
        $display("[FAIL] %0t ns: timeout %s", $time, msg);
        print_verdict();
    endtask : stall

    // one single word transfer; called just after a rising edge
    task automatic ahb_xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                            output logic [31:0] rd);
        int i;
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) stall("address phase");
        htrans <= 2'b00;
        hwdata <= wd;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) stall("data phase");
        rd = hrdata;
        chk(hresp, 1'b0, "okay response");
    endtask : ahb_xfer

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        ahb_xfer(1'b1, idx, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        ahb_xfer(1'b0, idx, 32'h0, d);
        chk(d, exp, msg);
    endtask : rd_chk

    // follow the entry in use to a target, one step at a time, then see it held
    task automatic wait_entry(input logic [2:0] tgt);
        logic [2:0] prev;
        int         i;
        int         gap;
        bit         moved;
        bit         lost;
        prev  = entry;
        gap   = 0;
        moved = 0;
        lost  = 0;
        for (i = 0; i < 200; i++) begin
            @(negedge clk);
            gap++;
            if (entry !== prev) begin
                chk({1'b0, entry} === {1'b0, prev} + 4'h1 ||
                    {1'b0, prev} === {1'b0, entry} + 4'h1, 1, "entry jump");
                if (moved) chk(gap, `RFPA_STEP_CYC, "step length");
                moved = 1;
                gap   = 0;
                prev  = entry;
            end
            if (entry === tgt) break;
        end
        if (i == 200) stall("ramp target");
        for (i = 0; i < 3 * `RFPA_STEP_CYC; i++) begin
            @(negedge clk);
            if (entry !== tgt) lost = 1;
        end
        chk(lost, 0, "final entry held");
        @(posedge clk);
    endtask : wait_entry

    // raise calibration done with a result, long enough to pass the synchroniser
    task automatic pulse(input logic [3:0] res);
        pump_cal_result <= res;
        cal_done        <= 1'b1;
        repeat (8) @(posedge clk);
        cal_done        <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse

    // ********************************************************************
    // scenarios
    // ********************************************************************
    task automatic t_reset();
        rd_chk(`RFPA_IDX_RX_TRIM, 32'h56, "rx trim reset");
        rd_chk(`RFPA_IDX_TX_CFG, 32'h10, "tx cfg reset");
        rd_chk(`RFPA_IDX_CAL_A, 32'ha9, "cal reset");
        chk(rx_trim, 8'h56, "rx trim out");
        chk(tx_lo, 2'h1, "tx lo out");
        chk(pwr_idx, 3'h0, "index out");
        chk(cal_cfg, 2'h2, "cal cfg out");
        chk(cal_run, 1'b1, "pump stage out");
        chk(pump_current, 4'h9, "pump out");
        chk(entry, 3'h0, "entry out");
        $display("test reset values done");
    endtask : t_reset

    task automatic t_rw();
        wr(`RFPA_IDX_RX_TRIM, 32'h000000a9);
        wr(`RFPA_IDX_TX_CFG, 32'hffffffff);
        rd_chk(`RFPA_IDX_RX_TRIM, 32'ha9, "rx trim back");
        rd_chk(`RFPA_IDX_TX_CFG, 32'h37, "tx cfg unused bits");
        chk(rx_trim, 8'ha9, "rx trim out");
        chk(tx_lo, 2'h3, "tx lo out");
        wr(16'hdf1d, 32'h000000ff);
        rd_chk(16'hdf1d, 32'h0, "unmapped read");
        rd_chk(`RFPA_IDX_RX_TRIM, 32'ha9, "unmapped write ignored");
        for (int k = 0; k < 8; k++) begin
            wr(`RFPA_IDX_TX_CFG, k);
            rd_chk(`RFPA_IDX_TX_CFG, k, "index back");
            chk(pwr_idx, k, "index out");
        end
        $display("test register access done");
    endtask : t_rw

    task automatic t_cal();
        wr(`RFPA_IDX_CAL_A, 32'h43);
        rd_chk(`RFPA_IDX_CAL_A, 32'h43, "cal back");
        chk(cal_run, 1'b0, "pump stage off");
        chk(cal_cfg, 2'h1, "cal cfg out");
        pulse(4'h5);
        chk(pump_current, 4'h3, "no capture when off");
        wr(`RFPA_IDX_CAL_A, 32'h5c);
        rd_chk(`RFPA_IDX_CAL_A, 32'h5c, "cal back");
        chk(cal_run, 1'b1, "pump stage on");
        pulse(4'h6);
        chk(pump_current, 4'h6, "result captured");
        rd_chk(`RFPA_IDX_CAL_A, 32'h56, "result readable");
        wr(`RFPA_IDX_CAL_A, 32'h5c);
        rd_chk(`RFPA_IDX_CAL_A, 32'h5c, "result restored");
        chk(pump_current, 4'hc, "restored out");
        $display("test calibration done");
    endtask : t_cal

    task automatic t_ramp();
        wr(`RFPA_IDX_RAMP_CTRL, 32'h0);
        wr(`RFPA_IDX_TX_CFG, 32'h15);
        tx_active <= 1'b1;
        wait_entry(3'h5);
        rd_chk(`RFPA_IDX_RAMP_STAT, {27'h0, RFPA_HOLD, 3'h5}, "ramp hold");
        tx_active <= 1'b0;
        wait_entry(3'h0);
        rd_chk(`RFPA_IDX_RAMP_STAT, {27'h0, RFPA_IDLE, 3'h0}, "ramp idle");
        $display("test power ramp done");
    endtask : t_ramp

    task automatic t_ask();
        wr(`RFPA_IDX_RAMP_CTRL, 32'h1);
        wr(`RFPA_IDX_TX_CFG, 32'h13);
        rd_chk(`RFPA_IDX_RAMP_CTRL, 32'h1, "ask mode back");
        ask_symbol <= 1'b1;
        tx_active  <= 1'b1;
        wait_entry(3'h3);
        ask_symbol <= 1'b0;
        wait_entry(3'h0);
        ask_symbol <= 1'b1;
        wait_entry(3'h3);
        tx_active  <= 1'b0;
        wait_entry(3'h0);
        $display("test ask shaping done");
    endtask : t_ask

    // ********************************************************************
    // main sequence
    // ********************************************************************
    initial begin
        err_total       = 0;
        n_checks        = 0;
        rst             = 1'b1;
        hsel            = 1'b0;
        haddr           = 32'h0;
        htrans          = 2'b00;
        hwrite          = 1'b0;
        hsize           = 3'b010;
        hwdata          = 32'h0;
        tx_active       = 1'b0;
        ask_symbol      = 1'b0;
        cal_done        = 1'b0;
        pump_cal_result = 4'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_rw();
        t_cal();
        t_ramp();
        t_ask();
        print_verdict();
    end

endmodule : tb_top
